// *** hdl/oc_hiccup_map.vh ***
// Purpose: Constants for the over-current hiccup sequencer
// Assumes: 200 MHz system clock, phase clock arrives as a one-cycle enable
// Notes:   Counts are in phase clock pulses
//
// Contract
// - Watch over-current flag; trip starts shutdown
// - Shutdown tristates all PWM, drops power good
// - Hold shutdown for 2048 phase clocks, retry
// - Over-current during soft-start restarts the wait
// - Hiccup repeats at most seven times, counted
// - Eighth attempt failing latches off, no restart
// - Latch clears only on enable low or POR
// - Successful soft-start: run, power good, clear count
// - Blank over-current while voltage code changes
// - Soft-start timed by eleven-bit phase clock counter
`ifndef OC_HICCUP_MAP_VH
`define OC_HICCUP_MAP_VH

`define PHASE_CNT_W     11
`define WAIT_CYCLES     11'h7_FF
`define SS_LAST         11'h7_FF
`define ATTEMPT_W       3
`define MAX_RETRIES     3'h7
`define NUM_PHASES      4

`endif

// *** hdl/pin_sync3.v ***
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Pin is asynchronous to clk
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 (
  input  wire clk,
  input  wire reset,
  input  wire pinIn,
  output reg  pinOut
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      pinOut <= 1'b0;
    end else begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        pinOut <= s3_ff;
      end
    end
  end
endmodule

// *** hdl/overcurrent_hiccup_sequencer.v ***
// Purpose: Over-current hiccup sequencer with latch-off for a multi-phase buck
// Assumes: phaseTick is a one-cycle enable, one per phase clock pulse
// Notes:   Analog comparator outputs are synchronised; control inputs are not
//          A trip in run counts as a failed attempt; only a full soft-start
//          span or a loss of enable or POR clears the count
`timescale 1ns/1ps
`include "oc_hiccup_map.vh"
module overcurrent_hiccup_sequencer (
  input  wire                     clk,
  input  wire                     reset,
  input  wire                     phaseTick,
  input  wire                     overCurrent,
  input  wire                     enableOk,
  input  wire                     porOk,
  input  wire                     voltageCodeChanging,
  input  wire [`NUM_PHASES-1:0]   pwmIn,
  output wire [`NUM_PHASES-1:0]   pwmOut,
  output wire [`NUM_PHASES-1:0]   pwmOe,
  output wire                     powerGoodOut,
  output wire                     powerGoodOe,
  output wire [1:0]               seqState,
  output wire                     latchedOff,
  output wire [`ATTEMPT_W-1:0]    failCount
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [1:0] ST_OFF  = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_SS   = 2'b10;
  localparam [1:0] ST_RUN  = 2'b11;

  wire ocSync;
  wire enSync;
  wire porSync;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // PWM pins are driven only while a soft-start or normal run is live
  function isDriving;
    input [1:0] st;
    begin
      isDriving = (st == ST_SS) | (st == ST_RUN);
    end
  endfunction

  // Power good is released only once a soft-start has run its full span
  function isRunning;
    input [1:0] st;
    begin
      isRunning = (st == ST_RUN);
    end
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // The comparators and monitors are analog and free-running, so each
  // passes three flops; the agreement filter costs up to four cycles
  // of trip latency, which is small against one phase clock period
  pin_sync3 u_syncOc (
    .clk    (clk),
    .reset  (reset),
    .pinIn  (overCurrent),
    .pinOut (ocSync)
  );

  pin_sync3 u_syncEn (
    .clk    (clk),
    .reset  (reset),
    .pinIn  (enableOk),
    .pinOut (enSync)
  );

  pin_sync3 u_syncPor (
    .clk    (clk),
    .reset  (reset),
    .pinIn  (porOk),
    .pinOut (porSync)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [1:0]              state_ff;
  reg [1:0]              nxt_state;
  reg [`PHASE_CNT_W-1:0] cnt_ff;
  reg [`PHASE_CNT_W-1:0] nxt_cnt;
  reg [`ATTEMPT_W-1:0]   fails_ff;
  reg [`ATTEMPT_W-1:0]   nxt_fails;
  reg                    latch_ff;
  reg                    nxt_latch;
  reg                    power_good_flag_ff;
  reg                    drive_ff;
  reg [`NUM_PHASES-1:0]  pwm_ff;

  // ---------------------------------------------------------------
  // Trip detection
  // ---------------------------------------------------------------
  // Blanked during a code change so the capacitor charging current cannot trip
  wire ocTrip  = ocSync & ~voltageCodeChanging;
  wire enabled = enSync & porSync;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_fails = fails_ff;
    nxt_latch = latch_ff;
    if (!enabled) begin
      // Only enable or supply loss clears the latch-off
      nxt_state = ST_OFF;
      nxt_cnt   = {`PHASE_CNT_W{1'b0}};
      nxt_fails = {`ATTEMPT_W{1'b0}};
      nxt_latch = 1'b0;
    end else begin
      case (state_ff)
        ST_OFF: begin
          // Power-up goes straight to soft-start; once latched, only a
          // disable (handled above) gets the sequencer out of here
          if (!latch_ff) begin
            nxt_state = ST_SS;
            nxt_cnt   = {`PHASE_CNT_W{1'b0}};
          end
        end
        ST_WAIT: begin
          // Shutdown held for the full phase-clock count
          if (phaseTick) begin
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == `WAIT_CYCLES) begin
              nxt_state = ST_SS;
              nxt_cnt   = {`PHASE_CNT_W{1'b0}};
            end
          end
        end
        ST_SS: begin
          if (ocTrip) begin
            // Eighth failed attempt latches off until a disable or supply loss
            if (fails_ff == `MAX_RETRIES) begin
              nxt_state = ST_OFF;
              nxt_latch = 1'b1;
            end else begin
              nxt_state = ST_WAIT;
              nxt_fails = fails_ff + 1'b1;
              nxt_cnt   = {`PHASE_CNT_W{1'b0}};
            end
          end else if (phaseTick) begin
            nxt_cnt = cnt_ff + 1'b1;
            if (cnt_ff == `SS_LAST) begin
              nxt_state = ST_RUN;
              nxt_fails = {`ATTEMPT_W{1'b0}};
              nxt_cnt   = {`PHASE_CNT_W{1'b0}};
            end
          end
        end
        default: begin
          // Normal run: any unblanked trip starts a hiccup wait
          if (ocTrip) begin
            nxt_state = ST_WAIT;
            nxt_fails = fails_ff + 1'b1;
            nxt_cnt   = {`PHASE_CNT_W{1'b0}};
          end
        end
      endcase
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_OFF;
      cnt_ff   <= {`PHASE_CNT_W{1'b0}};
      fails_ff <= {`ATTEMPT_W{1'b0}};
      latch_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      fails_ff <= nxt_fails;
      latch_ff <= nxt_latch;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // Enables are decoded from the next state so pins switch on the same
  // edge as the state, with no extra cycle of drive after a trip
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      power_good_flag_ff <= 1'b0;
      drive_ff <= 1'b0;
      pwm_ff   <= {`NUM_PHASES{1'b0}};
    end else begin
      power_good_flag_ff <= isRunning(nxt_state);
      drive_ff <= isDriving(nxt_state);
      pwm_ff   <= pwmIn;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // PWM data is registered once and otherwise untouched; only its
  // enable is sequenced, which costs one cycle of pulse delay
  genvar i;
  generate
    for (i = 0; i < `NUM_PHASES; i = i + 1) begin : g_phase
      assign pwmOut[i] = pwm_ff[i];
      assign pwmOe[i]  = drive_ff;
    end
  endgenerate

  // Open-drain: drive low whenever power is not good
  assign powerGoodOut = 1'b0;
  assign powerGoodOe  = ~power_good_flag_ff;
  assign seqState     = state_ff;
  assign latchedOff   = latch_ff;
  assign failCount    = fails_ff;
endmodule

// *** verif/oc_hiccup_assertions.sv ***
// Purpose: Port assertions for the hiccup sequencer
// Assumes: seqState 0 off, 1 wait, 2 soft-start, 3 run
// Notes:   Bound from the testbench top
`timescale 1ns/1ps
module oc_hiccup_assertions (
  input wire       clk,
  input wire       reset,
  input wire       voltageCodeChanging,
  input wire [3:0] pwmOe,
  input wire       powerGoodOut,
  input wire       powerGoodOe,
  input wire [1:0] seqState,
  input wire       latchedOff,
  input wire [2:0] failCount
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  oe_follow_a: assert property (pwmOe == {4{seqState[1]}}) else $error("pwm enable");
  pg_follow_a: assert property (powerGoodOe == (seqState != 2'h3)) else $error("pg");
  pg_low_a: assert property (!powerGoodOut) else $error("pg data");
  wait_from_a: assert property (seqState == 2'h1 && $past(seqState) != 2'h1
    |-> $past(seqState[1])) else $error("wait entry");
  fail_inc_a: assert property ($rose(seqState == 2'h1)
    |-> failCount == $past(failCount) + 3'h1) else $error("fail count");
  latch_off_a: assert property (latchedOff |-> !seqState && !pwmOe) else $error("latch");
  run_clear_a: assert property (seqState == 2'h3 && $past(seqState) == 2'h2
    |-> !failCount) else $error("run count");
  blank_a: assert property (voltageCodeChanging && seqState == 2'h3
    |=> seqState != 2'h1) else $error("blanking");
endmodule

// *** verif/mosfet_driver_model.sv ***
// Purpose: Driver stage and power monitor beside the sequencer
// Assumes: Undriven PWM turns both switches off
// Notes:   Power good has a pull-up
`timescale 1ns/1ps
module mosfet_driver_model (
  input  wire [3:0] pwmOut,
  input  wire [3:0] pwmOe,
  input  wire       powerGoodOe,
  output wire [3:0] phaseOn,
  output wire       pwrGood
);
  assign phaseOn = pwmOut & pwmOe;
  assign pwrGood = ~powerGoodOe;
endmodule

// *** verif/tb_overcurrent_hiccup_sequencer.sv ***
// Purpose: Hiccup, latch-off and blanking checks
// Assumes: Phase clock tick every other cycle
// Notes:   Each change of the state tuple pops one note
`timescale 1ns/1ps
module tb_overcurrent_hiccup_sequencer;
  reg        clk = 0, reset = 1, overCurrent = 0, enableOk = 1, codeChanging = 0;
  reg        phaseTick = 0, porOk = 1;
  reg  [3:0] pwmIn = 0, pwmPrev = 0;
  integer    ticks = 0, tickMark = 0;
  wire [3:0] pwmOut, pwmOe, phaseOn;
  wire       powerGoodOut, powerGoodOe, latchedOff, pwrGood;
  wire [1:0] seqState;
  wire [2:0] failCount;
  reg  [6:0] expQ[$];
  reg  [6:0] prev = 0, obs;
  integer    num_errors = 0, comparisons = 0, cycles = 0, i, k, seed = 32'hfd51;
  always #2.5 clk = ~clk;
  overcurrent_hiccup_sequencer i_dut (.clk(clk), .reset(reset), .phaseTick(phaseTick),
    .overCurrent(overCurrent), .enableOk(enableOk), .porOk(porOk),
    .voltageCodeChanging(codeChanging), .pwmIn(pwmIn), .pwmOut(pwmOut), .pwmOe(pwmOe),
    .powerGoodOut(powerGoodOut), .powerGoodOe(powerGoodOe), .seqState(seqState),
    .latchedOff(latchedOff), .failCount(failCount));
  mosfet_driver_model i_drv (.pwmOut(pwmOut), .pwmOe(pwmOe), .powerGoodOe(powerGoodOe),
    .phaseOn(phaseOn), .pwrGood(pwrGood));
  task chk(input [11:0] seen, input [11:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t state %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task note(input l, input [2:0] f, input [1:0] s);
    expQ.push_back({s == 2'h3, l, f, s});
  endtask
  task stateWait(input [1:0] s);
    for (i = 0; i < 10000 && seqState !== s; i = i + 1) @(posedge clk);
  endtask
  task trip;
    begin
      overCurrent <= 1'b1;
      repeat (8) @(posedge clk);
      overCurrent <= 1'b0;
    end
  endtask
  task summarize;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    pwmIn <= 4'($random(seed));
    phaseTick <= ~phaseTick;
    if (phaseTick) ticks = ticks + 1;
    cycles = cycles + 1;
    if (cycles > 90000) begin
      num_errors = num_errors + 1;
      summarize;
    end
  end
  // Latched count is masked: only the latch itself is specified
  always @(posedge clk) begin
    #1;
    obs = {pwrGood, latchedOff, latchedOff ? 3'h0 : failCount, seqState};
    if (!reset) chk(phaseOn, seqState[1] ? pwmPrev : 4'h0);
    pwmPrev = pwmIn;
    if (!reset && obs !== prev) begin
      chk(obs, expQ.size() ? expQ.pop_front() : 7'h7f);
      if ((prev[1:0] == 2'h1 && obs[1:0] == 2'h2) || (prev[1:0] == 2'h2 && obs[1:0] == 2'h3))
        chk(ticks - tickMark, 12'h800);
      tickMark = ticks;
      prev = obs;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    note(0, 0, 2);
    note(0, 0, 3);
    stateWait(2'h3);
    codeChanging <= 1'b1;
    trip;
    repeat (8) @(posedge clk);
    codeChanging <= 1'b0;
    note(0, 1, 1);
    note(0, 1, 2);
    note(0, 0, 3);
    trip;
    stateWait(2'h3);
    for (k = 1; k < 8; k = k + 1) begin
      note(0, k[2:0], 1);
      note(0, k[2:0], 2);
      trip;
      stateWait(2'h2);
      repeat (100) @(posedge clk);
    end
    note(1, 0, 0);
    trip;
    repeat (3000) @(posedge clk);
    enableOk <= 1'b0;
    note(0, 0, 0);
    repeat (10) @(posedge clk);
    enableOk <= 1'b1;
    note(0, 0, 2);
    note(0, 0, 3);
    stateWait(2'h3);
    repeat (10) @(posedge clk);
    porOk <= 1'b0;
    note(0, 0, 0);
    repeat (10) @(posedge clk);
    porOk <= 1'b1;
    note(0, 0, 2);
    note(0, 0, 3);
    stateWait(2'h3);
    repeat (10) @(posedge clk);
    chk(12'(expQ.size()), 12'h000);
    summarize;
  end
endmodule
bind overcurrent_hiccup_sequencer oc_hiccup_assertions i_chk (.clk(clk), .reset(reset),
  .voltageCodeChanging(voltageCodeChanging), .pwmOe(pwmOe), .powerGoodOut(powerGoodOut),
  .powerGoodOe(powerGoodOe), .seqState(seqState), .latchedOff(latchedOff),
  .failCount(failCount));
